// >>> hdl/pblac_pkg.sv
package pblac_pkg;

  localparam logic [3:0] PBLAC_BE_ALL = 4'h0;
  localparam logic [3:0] PBLAC_BE_B0  = 4'hE;
  localparam logic [3:0] PBLAC_BE_B1  = 4'hD;
  localparam logic [3:0] PBLAC_BE_B2  = 4'hB;
  localparam logic [3:0] PBLAC_BE_B3  = 4'h7;
  localparam logic [3:0] PBLAC_BE_LO  = 4'hC;
  localparam logic [3:0] PBLAC_BE_HI  = 4'h3;
  localparam logic [3:0] PBLAC_BE_NONE = 4'hF;

  localparam logic [4:0] PBLAC_OFS_DATA_PORT = 5'h10;
  localparam logic [4:0] PBLAC_OFS_STA_LAST  = 5'h0F;
  localparam logic       PBLAC_RST_DWORD     = 1'b0;

  typedef enum logic [1:0] {
    PBLAC_MK_DESC_RD = 2'h0,
    PBLAC_MK_TX_RD   = 2'h1,
    PBLAC_MK_DESC_WR = 2'h2,
    PBLAC_MK_RX_WR   = 2'h3
  } pblac_mkind_e;

  typedef struct packed {
    logic         valid;
    pblac_mkind_e kind;
    logic [31:0]  addr;
    logic [1:0]   first_byte;
    logic [2:0]   nbytes;
    logic         byte_wr;
    logic [31:0]  wdata;
  } pblac_mreq_s;

  typedef struct packed {
    logic        valid;
    logic        rd;
    logic [4:0]  offset;
    logic [3:0]  be_n;
    logic [31:0] wdata;
  } pblac_treq_s;

  typedef struct packed {
    logic        valid;
    logic        is_rd;
    logic [31:0] addr;
    logic [3:0]  be_n;
    logic [31:0] data;
  } pblac_mcyc_s;

  typedef struct packed {
    logic        valid;
    logic        legal;
    logic        wr_en;
    logic        rd;
    logic        dword;
    logic [4:0]  offset;
    logic [3:0]  be_n;
    logic [31:0] data;
  } pblac_tacc_s;

endpackage : pblac_pkg

// >>> hdl/pblac_top.sv
`timescale 1ns/100ps
module pblac_top (
  input  wire logic               clk_sys_in,
  input  wire logic               rst_n_in,
  input  wire pblac_pkg::pblac_mreq_s mreq_in,
  input  wire logic [31:0]        mst_rdata_in,
  input  wire logic               mst_rvalid_in,
  input  wire pblac_pkg::pblac_treq_s treq_in,
  input  wire logic [31:0]        reg_rdata_in,
  input  wire logic               ext_width_sel_in,
  output pblac_pkg::pblac_mcyc_s  mcyc_out,
  output logic [31:0]             mst_rx_data_out,
  output logic [3:0]              mst_rx_keep_out,
  output logic                    mst_rx_valid_out,
  output pblac_pkg::pblac_tacc_s  tacc_out,
  output logic [31:0]             tgt_rdata_out,
  output logic                    dword_io_mode_out
);
  import pblac_pkg::*;

  // Master side: lane keep mask for the dword being fetched
  logic [3:0]  keep_q;
  logic [3:0]  keep_d;
  pblac_mcyc_s mcyc_q;
  pblac_mcyc_s mcyc_d;
  logic [31:0] rx_data_q;
  logic [31:0] rx_data_d;
  logic [3:0]  rx_keep_q;
  logic [3:0]  rx_keep_d;
  logic        rx_valid_q;
  logic        rx_valid_d;
  logic [3:0]  wr_be_n;
  logic [2:0]  last_byte;

  always_comb begin
    wr_be_n   = PBLAC_BE_NONE;
    last_byte = 3'({1'b0, mreq_in.first_byte} + mreq_in.nbytes - 3'h1);
    for (int i = 0; i < 4; i++) begin
      if ((3'(i) >= {1'b0, mreq_in.first_byte}) && (3'(i) <= last_byte)) begin
        wr_be_n[i] = 1'b0;
      end
    end
  end

  always_comb begin
    mcyc_d     = mcyc_q;
    mcyc_d.valid = 1'b0;
    keep_d     = keep_q;
    rx_data_d  = rx_data_q;
    rx_keep_d  = rx_keep_q;
    rx_valid_d = 1'b0;
    if (mreq_in.valid) begin
      mcyc_d.valid = 1'b1;
      mcyc_d.addr  = {mreq_in.addr[31:2], 2'b00};
      mcyc_d.data  = mreq_in.wdata;
      unique case (mreq_in.kind)
        PBLAC_MK_DESC_RD, PBLAC_MK_TX_RD: begin
          mcyc_d.is_rd = 1'b1;
          mcyc_d.be_n  = PBLAC_BE_ALL;
          keep_d       = ~wr_be_n;
          if (mreq_in.kind == PBLAC_MK_DESC_RD) begin
            keep_d = 4'hF;
          end
        end
        PBLAC_MK_DESC_WR: begin
          mcyc_d.is_rd = 1'b0;
          // Descriptors only ever take the full dword or the top status byte
          mcyc_d.be_n  = mreq_in.byte_wr ? PBLAC_BE_B3 : PBLAC_BE_ALL;
        end
        PBLAC_MK_RX_WR: begin
          mcyc_d.is_rd = 1'b0;
          // Enables cover one contiguous run of lanes from first_byte to last_byte, never with holes
          mcyc_d.be_n  = wr_be_n;
        end
      endcase
    end
    if (mst_rvalid_in) begin
      rx_data_d  = mst_rdata_in;
      rx_keep_d  = keep_q;
      rx_valid_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      mcyc_q     <= '0;
      keep_q     <= 4'h0;
      rx_data_q  <= 32'h0000_0000;
      rx_keep_q  <= 4'h0;
      rx_valid_q <= 1'b0;
    end else begin
      mcyc_q     <= mcyc_d;
      keep_q     <= keep_d;
      rx_data_q  <= rx_data_d;
      rx_keep_q  <= rx_keep_d;
      rx_valid_q <= rx_valid_d;
    end
  end

  // Target side: mode latch, legality check, lane steering
  logic        dword_q;
  logic        dword_d;
  pblac_tacc_s tacc_q;
  pblac_tacc_s tacc_d;
  logic [31:0] trd_q;
  logic [31:0] trd_d;
  logic        rd_pend_q;
  logic        rd_pend_d;
  logic [3:0]  rd_be_q;
  logic [3:0]  rd_be_d;
  logic        rd_full_q;
  logic        rd_full_d;
  logic        station;
  logic        legal;

  always_comb begin
    station = (treq_in.offset <= PBLAC_OFS_STA_LAST);
    legal   = 1'b0;
    if (dword_q) begin
      legal = (treq_in.be_n == PBLAC_BE_ALL) && (treq_in.offset[1:0] == 2'b00);
    end else begin
      unique case (treq_in.be_n)
        PBLAC_BE_LO: legal = 1'b1;
        PBLAC_BE_HI: legal = 1'b1;
        PBLAC_BE_B0, PBLAC_BE_B1, PBLAC_BE_B2, PBLAC_BE_B3:
          legal = treq_in.rd && station;
        default: legal = 1'b0;
      endcase
    end
  end

  always_comb begin
    dword_d   = dword_q;
    tacc_d    = tacc_q;
    tacc_d.valid = 1'b0;
    tacc_d.wr_en = 1'b0;
    trd_d     = trd_q;
    rd_pend_d = 1'b0;
    rd_be_d   = rd_be_q;
    rd_full_d = rd_full_q;
    if (treq_in.valid) begin
      // The switch fires even on a data port write otherwise refused
      if (!treq_in.rd && treq_in.be_n == PBLAC_BE_ALL
          && treq_in.offset == PBLAC_OFS_DATA_PORT) begin
        dword_d = 1'b1;
      end
      tacc_d.valid  = 1'b1;
      tacc_d.legal  = legal;
      tacc_d.rd     = treq_in.rd;
      tacc_d.dword  = dword_q;
      tacc_d.offset = treq_in.offset;
      tacc_d.be_n   = treq_in.be_n;
      tacc_d.wr_en  = legal && !treq_in.rd;
      unique case (treq_in.be_n)
        PBLAC_BE_HI: tacc_d.data = {16'h0000, treq_in.wdata[31:16]};
        PBLAC_BE_LO: tacc_d.data = {16'h0000, treq_in.wdata[15:0]};
        default:     tacc_d.data = treq_in.wdata;
      endcase
      rd_pend_d = treq_in.rd && legal;
      rd_be_d   = treq_in.be_n;
      rd_full_d = station || ext_width_sel_in;
    end
    if (rd_pend_q) begin
      unique case (rd_be_q)
        PBLAC_BE_HI: trd_d = {reg_rdata_in[15:0], reg_rdata_in[15:0]};
        PBLAC_BE_B2: trd_d = {8'h00, reg_rdata_in[7:0], 8'h00, reg_rdata_in[7:0]};
        PBLAC_BE_B3: trd_d = {reg_rdata_in[15:8], 8'h00, reg_rdata_in[15:8], 8'h00};
        PBLAC_BE_B1: trd_d = {16'h0000, reg_rdata_in[15:8], 8'h00};
        PBLAC_BE_B0: trd_d = {24'h00_0000, reg_rdata_in[7:0]};
        PBLAC_BE_LO: trd_d = {16'h0000, reg_rdata_in[15:0]};
        default: begin
          // Reserved upper half read as zero unless fully defined
          trd_d = rd_full_q ? reg_rdata_in
                            : {16'h0000, reg_rdata_in[15:0]};
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      dword_q   <= PBLAC_RST_DWORD;
      tacc_q    <= '0;
      trd_q     <= 32'h0000_0000;
      rd_pend_q <= 1'b0;
      rd_be_q   <= 4'hF;
      rd_full_q <= 1'b0;
    end else begin
      dword_q   <= dword_d;
      tacc_q    <= tacc_d;
      trd_q     <= trd_d;
      rd_pend_q <= rd_pend_d;
      rd_be_q   <= rd_be_d;
      rd_full_q <= rd_full_d;
    end
  end

  assign mcyc_out          = mcyc_q;
  assign mst_rx_data_out   = rx_data_q;
  assign mst_rx_keep_out   = rx_keep_q;
  assign mst_rx_valid_out  = rx_valid_q;
  assign tacc_out          = tacc_q;
  assign tgt_rdata_out     = trd_q;
  assign dword_io_mode_out = dword_q;

endmodule : pblac_top

// >>> dv/pblac_top_asserts.sv
`timescale 1ns/100ps
module pblac_top_asserts
  import pblac_pkg::*;
(
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire pblac_mreq_s mreq_in,
  input wire pblac_treq_s treq_in,
  input wire pblac_mcyc_s mcyc_out,
  input wire pblac_tacc_s tacc_out,
  input wire logic        dword_io_mode_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  AST_MRD_ALL: assert property (mcyc_out.valid && mcyc_out.is_rd |-> mcyc_out.be_n == 4'h0)
    else $error("master read with partial enables");
  AST_MCYC_ALIGN: assert property (mreq_in.valid |=> mcyc_out.valid && mcyc_out.addr[1:0] == 2'h0)
    else $error("master cycle missing or unaligned");
  AST_MRD_KIND: assert property (mreq_in.valid && !mreq_in.kind[1] |=> mcyc_out.is_rd)
    else $error("read request gave no read cycle");
  AST_DESC_WR: assert property (mreq_in.valid && mreq_in.kind == PBLAC_MK_DESC_WR
    |=> mcyc_out.be_n inside {4'h0, 4'h7})
    else $error("descriptor write with bad enables");
  AST_DW_SET: assert property (treq_in.valid && !treq_in.rd && treq_in.be_n == 4'h0
    && treq_in.offset == PBLAC_OFS_DATA_PORT |=> dword_io_mode_out)
    else $error("dword mode not set");
  AST_DW_HOLD: assert property (dword_io_mode_out |=> dword_io_mode_out)
    else $error("dword mode dropped");
  AST_DW_LEGAL: assert property (treq_in.valid && treq_in.be_n == 4'h0 && treq_in.offset[1:0] == 2'h0
    |=> tacc_out.legal == $past(dword_io_mode_out))
    else $error("dword access legality wrong");
  AST_ILL_NOWR: assert property (tacc_out.valid && !tacc_out.legal |-> !tacc_out.wr_en)
    else $error("refused access wrote");
  AST_BYTE_STA: assert property (treq_in.valid && treq_in.be_n == 4'hE
    && treq_in.offset > PBLAC_OFS_STA_LAST |=> !tacc_out.legal)
    else $error("byte read outside station area");
endmodule : pblac_top_asserts
bind pblac_top pblac_top_asserts chk_u (.clk_sys_in, .rst_n_in, .mreq_in, .treq_in, .mcyc_out,
  .tacc_out, .dword_io_mode_out);

// >>> dv/pblac_bus_model.sv
`timescale 1ns/100ps
module pblac_bus_model #(
  parameter int          LAT   = 3,
  parameter logic [31:0] RDATA = 32'h89ABCDEF
) (
  input  wire logic                   clk_sys_in,
  input  wire pblac_pkg::pblac_mcyc_s mcyc_in,
  output logic [31:0]                 rdata_out,
  output logic                        rvalid_out
);
  int cnt_q = 0;
  initial rvalid_out = 1'h0;
  initial rdata_out = ~RDATA;
  // Full dword answer to every read; data flips when idle so stale lanes show
  always @(posedge clk_sys_in) begin
    rvalid_out <= 1'h0;
    rdata_out <= ~rdata_out;
    if (mcyc_in.valid && mcyc_in.is_rd) begin
      cnt_q <= LAT;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
      if (cnt_q == 1) begin
        rvalid_out <= 1'h1;
        rdata_out <= RDATA;
      end
    end
  end
endmodule : pblac_bus_model

// >>> dv/pblac_top_tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module pblac_top_tb;
  import pblac_pkg::*;
  typedef struct packed {
    logic rd; logic [4:0] ofs; logic [3:0] be; logic ext; logic [31:0] wd;
    logic lg; logic [31:0] rdx; logic md;
  } pblac_row_s;
  logic        clk_sys_in = 1'h0;
  logic        rst_n_in = 1'h0;
  logic        ext_width_sel_in = 1'h0;
  pblac_mreq_s mreq_in = '0;
  pblac_treq_s treq_in = '0;
  pblac_mcyc_s mcyc_out;
  pblac_tacc_s tacc_out;
  logic [31:0] mst_rdata_in, mst_rx_data_out, tgt_rdata_out;
  logic [3:0]  mst_rx_keep_out;
  logic        mst_rvalid_in, mst_rx_valid_out, dword_io_mode_out;
  int          bad_count = 0;
  int          checks = 0;
  pblac_row_s  rows[14];
  pblac_top dut_u (.clk_sys_in, .rst_n_in, .mreq_in, .mst_rdata_in, .mst_rvalid_in, .treq_in,
    .reg_rdata_in(32'hC3D4C3D4), .ext_width_sel_in, .mcyc_out, .mst_rx_data_out,
    .mst_rx_keep_out, .mst_rx_valid_out, .tacc_out, .tgt_rdata_out, .dword_io_mode_out);
  pblac_bus_model bus_u (.clk_sys_in, .mcyc_in(mcyc_out), .rdata_out(mst_rdata_in),
    .rvalid_out(mst_rvalid_in));
  initial forever #20 clk_sys_in = ~clk_sys_in;
  task give_verdict;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task mt(input pblac_mkind_e k, input logic [31:0] a, input logic [1:0] fb,
          input logic [2:0] nb, input logic bw);
    logic [3:0] kp;
    int n;
    kp = 4'(((5'h1 << nb) - 5'h1) << fb);
    mreq_in = '{1'h1, k, a, fb, nb, bw, 32'h5A5AA5A5};
    @(negedge clk_sys_in) mreq_in.valid = 1'h0;
    `CHK(mcyc_out.addr, {a[31:2], 2'h0})
    `CHK(mcyc_out.is_rd, !k[1])
    `CHK(mcyc_out.data, 32'h5A5AA5A5)
    `CHK(mcyc_out.be_n, !k[1] ? 4'h0 : k == PBLAC_MK_DESC_WR ? (bw ? 4'h7 : 4'h0) : ~kp)
    if (!k[1]) begin
      n = 0;
      while (mst_rx_valid_out !== 1'h1 && n < 20) begin
        @(negedge clk_sys_in) n++;
      end
      `CHK(mst_rx_keep_out, kp)
      `CHK(mst_rx_data_out, 32'h89ABCDEF)
    end
    // Let an edge pass so back to back calls never retoggle valid in one step
    @(negedge clk_sys_in);
  endtask : mt
  // Each row: rd, offset, enables, ext, wdata, legal, read data after, mode after
  initial begin
    rows[0]  = '{1'h1, 5'h04, 4'hC, 1'h0, 32'h0, 1'h1, 32'h0000C3D4, 1'h0};
    rows[1]  = '{1'h1, 5'h06, 4'h3, 1'h0, 32'h0, 1'h1, 32'hC3D4C3D4, 1'h0};
    rows[2]  = '{1'h1, 5'h00, 4'hE, 1'h0, 32'h0, 1'h1, 32'h000000D4, 1'h0};
    rows[3]  = '{1'h1, 5'h01, 4'hD, 1'h0, 32'h0, 1'h1, 32'h0000C300, 1'h0};
    rows[4]  = '{1'h1, 5'h02, 4'hB, 1'h0, 32'h0, 1'h1, 32'h00D400D4, 1'h0};
    rows[5]  = '{1'h1, 5'h0F, 4'h7, 1'h0, 32'h0, 1'h1, 32'hC300C300, 1'h0};
    rows[6]  = '{1'h1, 5'h14, 4'hE, 1'h0, 32'h0, 1'h0, 32'hC300C300, 1'h0};
    rows[7]  = '{1'h0, 5'h14, 4'hC, 1'h0, 32'h0000BEEF, 1'h1, 32'hC300C300, 1'h0};
    rows[8]  = '{1'h0, 5'h12, 4'h3, 1'h0, 32'hBEEF0000, 1'h1, 32'hC300C300, 1'h0};
    rows[9]  = '{1'h0, 5'h10, 4'h0, 1'h0, 32'h0, 1'h0, 32'hC300C300, 1'h1};
    rows[10] = '{1'h1, 5'h14, 4'h0, 1'h0, 32'h0, 1'h1, 32'h0000C3D4, 1'h1};
    rows[11] = '{1'h1, 5'h14, 4'h0, 1'h1, 32'h0, 1'h1, 32'hC3D4C3D4, 1'h1};
    rows[12] = '{1'h1, 5'h04, 4'hC, 1'h0, 32'h0, 1'h0, 32'hC3D4C3D4, 1'h1};
    rows[13] = '{1'h1, 5'h06, 4'h0, 1'h0, 32'h0, 1'h0, 32'hC3D4C3D4, 1'h1};
    repeat (5) @(negedge clk_sys_in);
    rst_n_in = 1'h1;
    foreach (rows[i]) begin
      treq_in = '{1'h1, rows[i].rd, rows[i].ofs, rows[i].be, rows[i].wd};
      ext_width_sel_in = rows[i].ext;
      @(negedge clk_sys_in) treq_in.valid = 1'h0;
      `CHK(tacc_out.legal, rows[i].lg)
      `CHK(tacc_out.wr_en, rows[i].lg & ~rows[i].rd)
      `CHK(dword_io_mode_out, rows[i].md)
      `CHK(tacc_out.dword, i > 9)
      `CHK(tacc_out.offset, rows[i].ofs)
      if (rows[i].lg && !rows[i].rd && !rows[i].md)
        `CHK(tacc_out.data[15:0], rows[i].be == 4'h3 ? rows[i].wd[31:16] : rows[i].wd[15:0])
      @(negedge clk_sys_in);
      `CHK(tgt_rdata_out, rows[i].rdx)
    end
    // Mode is sticky, so only reset can bring word mode back
    rst_n_in = 1'h0;
    @(negedge clk_sys_in) rst_n_in = 1'h1;
    `CHK(dword_io_mode_out, 1'h0)
    mt(PBLAC_MK_TX_RD, 32'h103, 2'h3, 3'h1, 1'h0);
    mt(PBLAC_MK_TX_RD, 32'h200, 2'h0, 3'h2, 1'h0);
    mt(PBLAC_MK_DESC_RD, 32'h40, 2'h0, 3'h4, 1'h0);
    mt(PBLAC_MK_RX_WR, 32'h301, 2'h1, 3'h2, 1'h0);
    mt(PBLAC_MK_RX_WR, 32'h302, 2'h2, 3'h2, 1'h0);
    mt(PBLAC_MK_DESC_WR, 32'h47, 2'h3, 3'h1, 1'h1);
    mt(PBLAC_MK_DESC_WR, 32'h48, 2'h0, 3'h4, 1'h0);
    give_verdict();
  end
  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
endmodule : pblac_top_tb
